// *** logic/pciu_group_flag.sv ***
`timescale 1ns/1ps
`default_nettype none
module pciu_group_flag (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // pin side
  input wire logic [7:0] change_i,
  input wire logic [7:0] mask_i,
  // clear sources
  input wire logic sw_clear_i,
  input wire logic handler_ack_i,
  // enables
  input wire logic group_enable_i,
  input wire logic global_enable_i,
  // results
  output logic flag_o,
  output logic set_o,
  output logic request_o
);
  import pciu_pkg::*;

  logic next_flag, next_set, next_request;

  // ----------------------------------------------------------------
  // flag and request
  // ----------------------------------------------------------------
  // a new change beats any clear landing in the same cycle
  always_comb
  begin
    next_set = |(change_i & mask_i);
    next_flag = next_set | (flag_o & ~sw_clear_i & ~handler_ack_i);
    next_request = next_flag & group_enable_i & global_enable_i;
  end

  // state registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      flag_o <= 1'b0;
      set_o <= 1'b0;
      request_o <= 1'b0;
    end
    else
    begin
      flag_o <= next_flag;
      set_o <= next_set;
      request_o <= next_request;
    end
  end

endmodule // pciu_group_flag
`default_nettype wire

// *** logic/pciu_pin_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module pciu_pin_sync (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // pad level, any direction
  input wire logic pin_i,
  // one-cycle pulse per accepted level change
  output logic change_o
);
  import pciu_pkg::*;

  logic s1, s2, s3, level, primed;
  logic fill1, fill2, fill3;
  logic next_s1, next_s2, next_s3, next_level, next_primed, next_change;
  logic next_fill1, next_fill2, next_fill3;

  // ----------------------------------------------------------------
  // three-stage synchroniser and edge detector
  // ----------------------------------------------------------------
  // s1 is read by s2 only; a level counts once s2 and s3 agree
  always_comb
  begin
    next_s1 = pin_i;
    next_s2 = s1;
    next_s3 = s2;
    next_level = level;
    next_primed = primed;
    next_change = 1'b0;
    // the fill chain marks when s3 holds a real pad sample, not the reset zero
    next_fill1 = 1'b1;
    next_fill2 = fill1;
    next_fill3 = fill2;
    if (fill3 && (s2 == s3))
    begin
      next_level = s3;
      next_primed = 1'b1;
      // rising and falling edges both count, first level after reset does not
      next_change = primed && (s3 != level);
    end
  end

  // state registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level <= 1'b0;
      primed <= 1'b0;
      change_o <= 1'b0;
      fill1 <= 1'b0;
      fill2 <= 1'b0;
      fill3 <= 1'b0;
    end
    else
    begin
      s1 <= next_s1;
      s2 <= next_s2;
      s3 <= next_s3;
      level <= next_level;
      primed <= next_primed;
      change_o <= next_change;
      fill1 <= next_fill1;
      fill2 <= next_fill2;
      fill3 <= next_fill3;
    end
  end

endmodule // pciu_pin_sync
`default_nettype wire

// *** logic/pciu_pkg.sv ***
`default_nettype none
package pciu_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int PCIU_GROUPS = 5;
  localparam int PCIU_PINS_PER_GROUP = 8;
  localparam int PCIU_PINS = PCIU_GROUPS * PCIU_PINS_PER_GROUP;
  localparam int PCIU_ADR_W = 10;
  localparam int PCIU_DAT_W = 32;
  localparam int PCIU_SEL_W = 4;
  localparam int PCIU_IDX_W = 8;
  localparam int PCIU_IDX_LSB = 2;

  // ----------------------------------------------------------------
  // register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [7:0] PCIU_IDX_GROUP_FLAGS = 8'h3B;
  localparam logic [7:0] PCIU_IDX_GROUP_ENABLES = 8'h68;
  localparam logic [7:0] PCIU_IDX_MASK_GROUP0 = 8'h6B;
  localparam logic [7:0] PCIU_IDX_MASK_GROUP1 = 8'h6C;
  localparam logic [7:0] PCIU_IDX_MASK_GROUP2 = 8'h6D;
  localparam logic [7:0] PCIU_IDX_MASK_GROUP3 = 8'h73;
  localparam logic [7:0] PCIU_IDX_MASK_GROUP4 = 8'h74;
  localparam logic [7:0] PCIU_IDX_GLOBAL_ENABLE = 8'h80;
  localparam logic [7:0] PCIU_IDX_EVENT_STATUS = 8'h81;
  localparam logic [7:0] PCIU_IDX_EVENT_MASK = 8'h82;

  // ----------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------
  localparam int PCIU_GLOBAL_BIT = 0;
  localparam int PCIU_WRITE_LANE = 0;
  localparam logic [2:0] PCIU_MASK_NONE = 3'h7;
  localparam logic [7:0] PCIU_MASK_RST = 8'h00;
  localparam logic [4:0] PCIU_GROUP_RST = 5'h00;
  localparam logic [31:0] PCIU_DAT_ZERO = 32'h00000000;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [PCIU_ADR_W-1:0] adr;
    logic [PCIU_SEL_W-1:0] sel;
    logic [PCIU_DAT_W-1:0] dat;
  } pciu_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [PCIU_DAT_W-1:0] dat;
  } pciu_wb_rsp_t;

  // port b sits in the low byte when the struct is flattened
  typedef struct packed {
    logic [7:0] port_f_pin;
    logic [7:0] port_e_pin;
    logic [7:0] port_d_pin;
    logic [7:0] port_c_pin;
    logic [7:0] port_b_pin;
  } pciu_pins_t;

endpackage
`default_nettype wire

// *** logic/pciu_top.sv ***
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module pciu_top (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire pciu_pkg::pciu_wb_req_t wb_req_i,
  output var pciu_pkg::pciu_wb_rsp_t wb_rsp_o,
  // port pins, sampled whatever their direction
  input wire pciu_pkg::pciu_pins_t pins_i,
  // processor interrupt logic
  input wire logic [pciu_pkg::PCIU_GROUPS-1:0] handler_ack_i,
  output logic [pciu_pkg::PCIU_GROUPS-1:0] group_request_o,
  // summary interrupt
  output var logic irq_o
);
  import pciu_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  // pin side
  logic [PCIU_PINS-1:0] pin_vec;
  logic [PCIU_PINS-1:0] pin_change;
  // group side
  logic [PCIU_GROUPS-1:0] group_flag;
  logic [PCIU_GROUPS-1:0] group_set;
  logic [PCIU_GROUPS-1:0] flag_clear;
  // register state
  logic [PCIU_GROUPS-1:0] group_enable;
  logic [PCIU_GROUPS-1:0] next_group_enable;
  logic [7:0] mask_reg [PCIU_GROUPS];
  logic [7:0] next_mask_reg [PCIU_GROUPS];
  logic global_enable;
  logic next_global_enable;
  logic [PCIU_GROUPS-1:0] event_status;
  logic [PCIU_GROUPS-1:0] next_event_status;
  logic [PCIU_GROUPS-1:0] event_mask;
  logic [PCIU_GROUPS-1:0] next_event_mask;
  // summary interrupt and bus decode
  logic status_read_clear;
  logic next_irq;
  pciu_wb_rsp_t next_wb_rsp;
  logic req_new;
  logic wr_low;
  logic [PCIU_IDX_W-1:0] req_idx;
  logic [2:0] wr_slot;
  logic [2:0] rd_slot;
  logic [7:0] wr_byte;

  // ----------------------------------------------------------------
  // decoding helpers
  // ----------------------------------------------------------------
  // maps a register index onto its mask register, or none
  // shared by the write and read paths so both agree on the map
  function automatic logic [2:0] mask_slot(input logic [PCIU_IDX_W-1:0] idx);
    logic [2:0] slot;
    slot = PCIU_MASK_NONE;
    unique case (idx)
      PCIU_IDX_MASK_GROUP0: slot = 3'h0;
      PCIU_IDX_MASK_GROUP1: slot = 3'h1;
      PCIU_IDX_MASK_GROUP2: slot = 3'h2;
      PCIU_IDX_MASK_GROUP3: slot = 3'h3;
      PCIU_IDX_MASK_GROUP4: slot = 3'h4;
      default: slot = PCIU_MASK_NONE;
    endcase
    return slot;
  endfunction

  // widens a group-wide field into a bus word, upper bits zero
  function automatic logic [PCIU_DAT_W-1:0] group_word(input logic [PCIU_GROUPS-1:0] bits);
    logic [PCIU_DAT_W-1:0] word;
    word = PCIU_DAT_ZERO;
    word[PCIU_GROUPS-1:0] = bits;
    return word;
  endfunction

  // keeps the group bits of a written byte, bits 7:5 have no storage
  function automatic logic [PCIU_GROUPS-1:0] group_field(input logic [7:0] value);
    logic [PCIU_GROUPS-1:0] bits;
    bits = value[PCIU_GROUPS-1:0];
    return bits;
  endfunction

  // widens a byte into a bus word
  function automatic logic [PCIU_DAT_W-1:0] byte_word(input logic [7:0] value);
    logic [PCIU_DAT_W-1:0] word;
    word = PCIU_DAT_ZERO;
    word[7:0] = value;
    return word;
  endfunction

  // ----------------------------------------------------------------
  // pin change detection
  // ----------------------------------------------------------------
  // port b lands on pins 7:0, then c, d, e, and port f on 39:32
  assign pin_vec = pins_i;

  // one synchroniser per pad; the pad level is watched even when driven
  // by the port itself, so toggling an output makes a software interrupt
  // limitation: pads are sampled on clk_i, so a change is only seen while
  // the clock runs; a sleep mode that stops clk_i needs a separate
  // asynchronous wake path in front of this block
  generate
    for (genvar p = 0; p < PCIU_PINS; p++)
    begin : g_pin
      pciu_pin_sync u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(pin_vec[p]),
        .change_o(pin_change[p])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // group flags and requests
  // ----------------------------------------------------------------
  // each group sees only its own port and raises only its own request
  // the request is registered inside the group, so an enable write shows
  // on group_request_o one cycle after the write is acknowledged
  generate
    for (genvar g = 0; g < PCIU_GROUPS; g++)
    begin : g_group
      pciu_group_flag u_flag (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .change_i(pin_change[g*PCIU_PINS_PER_GROUP +: PCIU_PINS_PER_GROUP]),
        .mask_i(mask_reg[g]),
        .sw_clear_i(flag_clear[g]),
        .handler_ack_i(handler_ack_i[g]),
        .group_enable_i(group_enable[g]),
        .global_enable_i(global_enable),
        .flag_o(group_flag[g]),
        .set_o(group_set[g]),
        .request_o(group_request_o[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // bus request decode
  // ----------------------------------------------------------------
  // a request is served once; ack drops the cycle after it rises
  // the ack term keeps a held request from being taken a second time
  // only byte lane 0 carries register data; other lanes are ignored
  always_comb
  begin
    req_new = wb_req_i.cyc & wb_req_i.stb & ~wb_rsp_o.ack;
    wr_low = req_new & wb_req_i.we & wb_req_i.sel[PCIU_WRITE_LANE];
    req_idx = wb_req_i.adr[PCIU_IDX_LSB +: PCIU_IDX_W];
    wr_slot = mask_slot(req_idx);
    rd_slot = mask_slot(req_idx);
    wr_byte = wb_req_i.dat[7:0];
  end

  // write-one strobes for the group flags, a zero leaves a flag alone
  // a pin change in the same cycle still wins inside the group flag
  always_comb
  begin
    flag_clear = PCIU_GROUP_RST;
    if (wr_low && (req_idx == PCIU_IDX_GROUP_FLAGS))
    begin
      flag_clear = group_field(wr_byte);
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  // next values of the enables and the summary interrupt mask
  // a write with byte lane 0 low is acknowledged but changes nothing
  always_comb
  begin
    next_group_enable = group_enable;
    next_global_enable = global_enable;
    next_event_mask = event_mask;
    if (wr_low)
    begin
      if (req_idx == PCIU_IDX_GROUP_ENABLES)
      begin
        next_group_enable = group_field(wr_byte);
      end
      if (req_idx == PCIU_IDX_GLOBAL_ENABLE)
      begin
        next_global_enable = wr_byte[PCIU_GLOBAL_BIT];
      end
      if (req_idx == PCIU_IDX_EVENT_MASK)
      begin
        next_event_mask = group_field(wr_byte);
      end
    end
  end

  // control state registers
  // enables clear on reset so no request can reach the core early
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      group_enable <= PCIU_GROUP_RST;
      global_enable <= 1'b0;
      event_mask <= PCIU_GROUP_RST;
    end
    else
    begin
      group_enable <= next_group_enable;
      global_enable <= next_global_enable;
      event_mask <= next_event_mask;
    end
  end

  // ----------------------------------------------------------------
  // mask registers
  // ----------------------------------------------------------------
  // one register per group; a cleared bit keeps its pin out of the flag
  generate
    for (genvar g = 0; g < PCIU_GROUPS; g++)
    begin : g_mask
      // a write to this group's index replaces the whole byte
      // the slot decode matches at most one group
      always_comb
      begin
        next_mask_reg[g] = mask_reg[g];
        if (wr_low && (wr_slot == 3'(g)))
        begin
          next_mask_reg[g] = wr_byte;
        end
      end

      // mask state, all clear after reset so no pin is watched
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          mask_reg[g] <= PCIU_MASK_RST;
        end
        else
        begin
          mask_reg[g] <= next_mask_reg[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // read data is latched with ack; unmapped indices answer zero
  // keeping dat at zero outside ack lets the fabric simply or the slaves
  always_comb
  begin
    next_wb_rsp.ack = req_new;
    next_wb_rsp.dat = PCIU_DAT_ZERO;
    status_read_clear = 1'b0;
    if (req_new && !wb_req_i.we)
    begin
      if (rd_slot != PCIU_MASK_NONE)
      begin
        next_wb_rsp.dat = byte_word(mask_reg[rd_slot]);
      end
      else
      begin
        unique case (req_idx)
          PCIU_IDX_GROUP_FLAGS: next_wb_rsp.dat = group_word(group_flag);
          PCIU_IDX_GROUP_ENABLES: next_wb_rsp.dat = group_word(group_enable);
          PCIU_IDX_GLOBAL_ENABLE: next_wb_rsp.dat[PCIU_GLOBAL_BIT] = global_enable;
          PCIU_IDX_EVENT_MASK: next_wb_rsp.dat = group_word(event_mask);
          PCIU_IDX_EVENT_STATUS:
          begin
            next_wb_rsp.dat = group_word(event_status);
            status_read_clear = 1'b1;
          end
          default: next_wb_rsp.dat = PCIU_DAT_ZERO;
        endcase
      end
    end
  end

  // bus answer register
  // ack is a single-cycle pulse; the master must drop stb at that edge
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_rsp_o.ack <= 1'b0;
      wb_rsp_o.dat <= PCIU_DAT_ZERO;
    end
    else
    begin
      wb_rsp_o <= next_wb_rsp;
    end
  end

  // ----------------------------------------------------------------
  // event status and summary interrupt
  // ----------------------------------------------------------------
  // a flag set in the cycle of a clearing read stays recorded
  // the interrupt is taken from the next values so irq_o and the status
  // register change on the same edge
  always_comb
  begin
    next_event_status = event_status;
    if (status_read_clear)
    begin
      next_event_status = PCIU_GROUP_RST;
    end
    next_event_status = next_event_status | group_set;
    next_irq = |(next_event_status & next_event_mask);
  end

  // event state registers
  // irq_o comes straight from this register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      event_status <= PCIU_GROUP_RST;
      irq_o <= 1'b0;
    end
    else
    begin
      event_status <= next_event_status;
      irq_o <= next_irq;
    end
  end

endmodule // pciu_top
`default_nettype wire

// *** verif/pciu_checker_props.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// port checks of the pin change unit
// ----------------------------------------
module pciu_checker (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // watched ports
  input wire pciu_pkg::pciu_wb_req_t wb_req_i,
  input wire pciu_pkg::pciu_wb_rsp_t wb_rsp_o,
  input wire pciu_pkg::pciu_pins_t pins_i,
  input wire logic [4:0] handler_ack_i,
  input wire logic [4:0] group_request_o,
  input wire logic irq_o
);
  import pciu_pkg::*;
  logic [39:0] pins_q;
  logic [3:0] quiet;
  logic [3:0] next_quiet;
  logic ack;
  logic wr;
  // short names for the bus answer and direction
  assign ack = wb_rsp_o.ack;
  assign wr = wb_req_i.we;
  // cycles since the pins last moved, saturating
  always_comb next_quiet = (pins_i != pins_q) ? 4'h0 : quiet + {3'h0, quiet != 4'hF};
  always_ff @(posedge clk_i)
  begin
    pins_q <= pins_i;
    quiet <= rst_i ? 4'h0 : next_quiet;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_take;
    wb_req_i.cyc && wb_req_i.stb && !ack;
  endsequence
  sequence s_answer;
    ack ##1 !ack;
  endsequence
  AST_BUS_ANSWER: assert property (s_take |=> s_answer)
    else $error("bus answer late");
  AST_ACK_PULSE: assert property (ack |=> !ack)
    else $error("ack too long");
  AST_RESET_QUIET: assert property (disable iff (1'b0)
    rst_i |=> !ack && !irq_o && group_request_o == 5'h00)
    else $error("outputs not idle after reset");
  AST_DAT_IDLE: assert property (!ack |-> wb_rsp_o.dat == 32'h00000000)
    else $error("read data without ack");
  AST_DAT_WIDTH: assert property (ack |-> wb_rsp_o.dat[31:8] == 24'h000000)
    else $error("upper read bits set");
  // an enable write reaches the registered request one cycle after its ack
  AST_REQ_CAUSE: assert property (
    (group_request_o & ~$past(group_request_o)) != 5'h00 && quiet > 4'h7
    |-> $past(ack && wr))
    else $error("request rose without cause");
  // a flag clear drops the request with the ack, an enable write one cycle later
  AST_REQ_HOLD: assert property (
    (($past(group_request_o) & ~group_request_o) & ~$past(handler_ack_i)) != 5'h00
    |-> (ack && wr) || $past(ack && wr))
    else $error("request dropped without cause");
  AST_HANDLER_CLR: assert property (
    (handler_ack_i & group_request_o) != 5'h00 && quiet > 4'h7
    |=> (group_request_o & $past(handler_ack_i)) == 5'h00)
    else $error("handler entry left request");
endmodule // pciu_checker
bind pciu_top pciu_checker u_props (.clk_i, .rst_i, .wb_req_i, .wb_rsp_o, .pins_i,
                                    .handler_ack_i, .group_request_o, .irq_o);
`default_nettype wire

// *** verif/pciu_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// processor interrupt entry model
// ----------------------------------------
module pciu_core_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // core side of the unit
  input wire logic [4:0] request_i,
  output logic [4:0] handler_ack_o,
  // bench control and record
  input wire logic auto_i,
  input wire logic [3:0] lat_i,
  output logic [4:0] entered_o
);
  logic [3:0] wait_cnt;
  // enter the lowest pending group after lat_i cycles, one pulse per entry
  always_ff @(posedge clk_i)
  begin
    handler_ack_o <= 5'h00;
    if (rst_i)
    begin
      wait_cnt <= 4'h0;
      entered_o <= 5'h00;
    end
    else if (auto_i && request_i != 5'h00 && handler_ack_o == 5'h00)
    begin
      wait_cnt <= wait_cnt + 4'h1;
      if (wait_cnt >= lat_i)
      begin
        handler_ack_o <= request_i & (~request_i + 5'h01);
        entered_o <= request_i & (~request_i + 5'h01);
        wait_cnt <= 4'h0;
      end
    end
  end
endmodule // pciu_core_model
`default_nettype wire

// *** verif/pin_change_interrupt_unit_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// self-checking bench
// ----------------------------------------
module pin_change_interrupt_unit_bench;
  import pciu_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  pciu_wb_req_t req = '0;
  pciu_wb_rsp_t rsp;
  pciu_pins_t pins;
  logic [4:0] hack;
  logic [4:0] grq;
  logic [4:0] ent;
  logic irq;
  logic auto = 1'b0;
  logic [3:0] lat = 4'h0;
  logic [31:0] rd;
  logic [7:0] ix[11] = '{8'h3B, 8'h68, 8'h6B, 8'h6C, 8'h6D, 8'h73, 8'h74, 8'h80, 8'h81,
                         8'h82, 8'h90};
  logic [7:0] wm[11] = '{8'h00, 8'h1F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h01, 8'h00,
                         8'h1F, 8'h00};
  int n_fail = 0;
  int n_tests = 0;
  int seed = 32'hB362;
  int flg = 0;
  int en = 0;
  int gie = 0;
  int ev = 0;
  int d;
  int n;
  // clock
  always #2.5 clk_i = ~clk_i;
  pciu_top dut (.clk_i, .rst_i, .wb_req_i(req), .wb_rsp_o(rsp), .pins_i(pins),
                .handler_ack_i(hack), .group_request_o(grq), .irq_o(irq));
  pciu_core_model core (.clk_i, .rst_i, .request_i(grq), .handler_ack_o(hack),
                        .auto_i(auto), .lat_i(lat), .entered_o(ent));
  // compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one classic bus cycle, held until ack
  task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] dat);
    int t;
    t = 0;
    @(posedge clk_i);
    req <= '{1'b1, 1'b1, we, {idx, 2'h0}, 4'hF, {24'h000000, dat}};
    do @(posedge clk_i); while (rsp.ack !== 1'b1 && ++t < 50);
    rd = rsp.dat;
    req <= '0;
    if (t >= 50) n_fail++;
  endtask
  // flip one pin and let the change settle
  task automatic tog(input int p, input int hit);
    @(posedge clk_i);
    pins[p] <= ~pins[p];
    flg |= hit << (p / 8);
    ev |= hit << (p / 8);
    repeat (8) @(posedge clk_i);
  endtask
  // flags, requests and interrupt against the model
  task automatic state;
    wb(1'b0, 8'h3B, 8'h00);
    chk("flags", rd, flg);
    chk("request", grq, gie ? flg & en : 0);
    chk("irq", irq, ev != 0);
  endtask
  task automatic end_of_test;
    if (n_fail == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // watchdog
  initial
  begin
    #200000;
    n_fail++;
    end_of_test;
  end
  // main sequence
  initial
  begin
    pins = {8'h5A, $random(seed)};
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    foreach (ix[i])
    begin
      wb(1'b0, ix[i], 8'h00);
      chk("reset", rd, 0);
    end
    foreach (ix[i])
    begin
      d = $random(seed);
      if (i != 8)
        wb(1'b1, ix[i], d[7:0]);
      wb(1'b0, ix[i], 8'h00);
      chk("readback", rd, i == 8 ? 0 : d & wm[i]);
    end
    gie = 1;
    wb(1'b1, 8'h80, 8'h01);
    wb(1'b1, 8'h82, 8'h1F);
    for (int g = 0; g < 5; g++)
    begin
      n = $random(seed) & 7;
      wb(1'b1, ix[2 + g], 8'h01 << n);
      en = 31 ^ (1 << g);
      wb(1'b1, 8'h68, en[7:0]);
      tog(8 * g + (n + 1) % 8, 0);
      state;
      tog(8 * g + n, 1);
      state;
      en = 31;
      wb(1'b1, 8'h68, 8'hFF);
      state;
      gie = 0;
      wb(1'b1, 8'h80, 8'h00);
      state;
      gie = 1;
      wb(1'b1, 8'h80, 8'h01);
      wb(1'b1, 8'h3B, 8'h00);
      state;
      flg = 0;
      wb(1'b1, 8'h3B, 8'h01 << g);
      state;
      tog(8 * g + n, 1);
      state;
      // a write-one clear landing on the edge of a new change leaves the flag set
      @(posedge clk_i);
      pins[8 * g + n] <= ~pins[8 * g + n];
      repeat (3) @(posedge clk_i);
      wb(1'b1, 8'h3B, 8'h01 << g);
      state;
      wb(1'b0, 8'h81, 8'h00);
      chk("status", rd, ev);
      ev = 0;
      auto <= 1'b1;
      lat <= 4'($random(seed));
      repeat (24) @(posedge clk_i);
      auto <= 1'b0;
      flg = 0;
      state;
      chk("entry", ent, 1 << g);
    end
    end_of_test;
  end
endmodule // pin_change_interrupt_unit_bench
`default_nettype wire
